// *** pcf_attr_reg.sv ***
// Purpose: One configuration register with a chosen access attribute
// Assumes: Writes arrive as a one-cycle strobe with full-word data
// Notes:   Sticky cells ignore the ordinary reset entirely
`timescale 1ns/1ps
module pcf_attr_reg #(
  parameter int         W       = 8,
  parameter int         KIND    = 0,
  parameter bit         STICKY  = 1'b0,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and resets
  input  wire logic         core_clk,
  input  wire logic         nrst,
  input  wire logic         pg_clr,
  // Software and hardware updates
  input  wire logic         wr_en,
  input  wire logic [W-1:0] wdata,
  input  wire logic [W-1:0] hw_set,
  // Stored value
  output logic      [W-1:0] q
);

  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;

  // Next value by attribute; hardware set wins over a same-cycle clear
  always_comb begin
    q_next = q_reg;
    if (wr_en && KIND == pcf_pkg::KIND_RW) begin
      q_next = wdata;
    end else if (wr_en && KIND == pcf_pkg::KIND_W1C) begin
      q_next = q_reg & ~wdata;
    end
    q_next = q_next | hw_set;
    if (pg_clr || (!STICKY && !nrst)) begin
      q_next = RST_VAL;
    end
  end

  always_ff @(posedge core_clk) begin
    q_reg <= q_next;
  end

  assign q = q_reg;

endmodule : pcf_attr_reg

// *** pcf_bank.sv ***
// Purpose: Attribute register bank and per-function enables over AHB-Lite
// Assumes: Straps and loader inputs synchronous to core_clk
// Notes:   Reads take one wait state, writes none; response always OKAY
`timescale 1ns/1ps
module pcf_bank #(
  parameter bit ALT_MGMT_WORD = 1'b0
) (
  // Clock and resets
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic        power_good_reset,
  // Auxiliary power state
  input  wire logic        aux_pwr_en,
  input  wire logic        pme_en,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  // Straps and fuse
  input  wire logic        first_port_disable_strap_n,
  input  wire logic        second_port_disable_strap_n,
  input  wire logic        usb_fuse_disable,
  // Non-volatile memory loader
  input  wire logic        nvm_valid,
  input  wire logic [7:0]  nvm_addr,
  input  wire logic [15:0] nvm_data,
  input  wire logic        nvm_done,
  // Hardware events
  input  wire logic [7:0]  evt_in,
  input  wire logic [7:0]  sticky_evt_in,
  input  wire logic [7:0]  sticky_ro_evt_in,
  // Function state
  output logic      [7:0]  func_active,
  output logic             init_done,
  output logic             deep_power_down
);

  // Bus slave state
  pcf_pkg::pcf_bus_t bus_reg;
  pcf_pkg::pcf_bus_t bus_next;
  logic [7:0]  addr_reg;
  logic [7:0]  addr_next;
  logic        hready_reg;
  logic        hready_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [31:0] rd_mux;
  logic        accept;

  // Register cell values
  logic [31:0] ctrl_q;
  logic [7:0]  status_q;
  logic [31:0] sticky_rw_q;
  logic [7:0]  sticky_w1c_q;
  logic [7:0]  sticky_ro_q;
  logic        pg_sticky;

  // Hardware-initialised enables
  logic [6:0]  fen_reg;
  logic [6:0]  fen_next;
  logic        sel_reg;
  logic        sel_next;
  logic        busy_reg;
  logic        busy_next;

  // Function map
  logic [7:0]  act_reg;
  logic [7:0]  act_next;
  logic [2:0]  owner_reg [8];
  logic [2:0]  owner_next [8];
  logic        dpd_reg;
  logic        dpd_next;

  // Configuration slot that a device function occupies
  function automatic logic [2:0] slot_of(input int fid, input logic [6:0] en,
                                         input logic sel);
    logic single;
    single = en[pcf_pkg::EN_LAN0] ^ en[pcf_pkg::EN_LAN1];
    case (fid)
      pcf_pkg::EN_LAN0: slot_of = (single || !sel) ? 3'h0 : 3'h1;
      pcf_pkg::EN_LAN1: slot_of = (single || sel) ? 3'h0 : 3'h1;
      pcf_pkg::EN_IDE:  slot_of = pcf_pkg::SLOT_IDE;
      pcf_pkg::EN_SER:  slot_of = pcf_pkg::SLOT_SER;
      pcf_pkg::EN_KCS:  slot_of = (en[pcf_pkg::EN_LAN0] || en[pcf_pkg::EN_LAN1]) ?
                                  pcf_pkg::SLOT_KCS : 3'h0;
      pcf_pkg::EN_USB:  slot_of = pcf_pkg::SLOT_USB;
      default:          slot_of = pcf_pkg::SLOT_BT;
    endcase
  endfunction : slot_of

  // Write strobe for one offset during a write data phase
  function automatic logic wr_hit(input pcf_pkg::pcf_bus_t st, input logic [7:0] a,
                                  input logic [7:0] target);
    wr_hit = (st == pcf_pkg::BUS_WRITE) && (a == target);
  endfunction : wr_hit

  // Sticky cells hold through power-good while aux power is in use
  assign pg_sticky = power_good_reset && !(aux_pwr_en || pme_en);

  // Ordinary control word; low bits pick the queried function slot
  pcf_attr_reg #(.W(32), .KIND(pcf_pkg::KIND_RW), .STICKY(1'b0),
                 .RST_VAL(32'h00000000)) u_ctrl (
    .core_clk (core_clk),
    .nrst     (nrst),
    .pg_clr   (power_good_reset),
    .wr_en    (wr_hit(bus_reg, addr_reg, pcf_pkg::ADDR_CTRL)),
    .wdata    (hwdata),
    .hw_set   (32'h00000000),
    .q        (ctrl_q)
  );

  // Ordinary event status
  pcf_attr_reg #(.W(8), .KIND(pcf_pkg::KIND_W1C), .STICKY(1'b0),
                 .RST_VAL(8'h00)) u_status (
    .core_clk (core_clk),
    .nrst     (nrst),
    .pg_clr   (power_good_reset),
    .wr_en    (wr_hit(bus_reg, addr_reg, pcf_pkg::ADDR_STATUS)),
    .wdata    (hwdata[7:0]),
    .hw_set   (evt_in),
    .q        (status_q)
  );

  // Sticky read/write word
  pcf_attr_reg #(.W(32), .KIND(pcf_pkg::KIND_RW), .STICKY(1'b1),
                 .RST_VAL(32'h00000000)) u_sticky_rw (
    .core_clk (core_clk),
    .nrst     (nrst),
    .pg_clr   (pg_sticky),
    .wr_en    (wr_hit(bus_reg, addr_reg, pcf_pkg::ADDR_STICKY_RW)),
    .wdata    (hwdata),
    .hw_set   (32'h00000000),
    .q        (sticky_rw_q)
  );

  // Sticky event status
  pcf_attr_reg #(.W(8), .KIND(pcf_pkg::KIND_W1C), .STICKY(1'b1),
                 .RST_VAL(8'h00)) u_sticky_w1c (
    .core_clk (core_clk),
    .nrst     (nrst),
    .pg_clr   (pg_sticky),
    .wr_en    (wr_hit(bus_reg, addr_reg, pcf_pkg::ADDR_STICKY_W1C)),
    .wdata    (hwdata[7:0]),
    .hw_set   (sticky_evt_in),
    .q        (sticky_w1c_q)
  );

  // Sticky read-only error record; software writes never reach it
  pcf_attr_reg #(.W(8), .KIND(pcf_pkg::KIND_RO), .STICKY(1'b1),
                 .RST_VAL(8'h00)) u_sticky_ro (
    .core_clk (core_clk),
    .nrst     (nrst),
    .pg_clr   (pg_sticky),
    .wr_en    (wr_hit(bus_reg, addr_reg, pcf_pkg::ADDR_STICKY_RO)),
    .wdata    (hwdata[7:0]),
    .hw_set   (sticky_ro_evt_in),
    .q        (sticky_ro_q)
  );

  // Bus slave: take the address phase, apply writes, stall reads one cycle
  assign accept = hsel && hready && htrans[1];
  always_comb begin
    bus_next    = pcf_pkg::BUS_IDLE;
    addr_next   = addr_reg;
    hready_next = 1'b1;
    rdata_next  = rdata_reg;
    if (bus_reg == pcf_pkg::BUS_READ && !hready_reg) begin
      rdata_next = rd_mux;                       // Regs already hold prior write
    end else if (accept) begin
      addr_next = haddr[7:0];
      if (hwrite) begin
        bus_next = pcf_pkg::BUS_WRITE;
      end else begin
        bus_next    = pcf_pkg::BUS_READ;
        hready_next = 1'b0;
      end
    end
    if (bus_reg == pcf_pkg::BUS_READ && !hready_reg) begin
      bus_next = pcf_pkg::BUS_READ;
    end
    if (!nrst) begin
      bus_next    = pcf_pkg::BUS_IDLE;
      addr_next   = 8'h00;
      hready_next = 1'b1;
      rdata_next  = 32'h00000000;
    end
  end

  always_ff @(posedge core_clk) begin
    bus_reg    <= bus_next;
    addr_reg   <= addr_next;
    hready_reg <= hready_next;
    rdata_reg  <= rdata_next;
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    rd_mux = 32'h00000000;
    case (addr_reg)
      pcf_pkg::ADDR_CTRL:       rd_mux = ctrl_q;
      pcf_pkg::ADDR_STATUS:     rd_mux = {24'h000000, status_q};
      pcf_pkg::ADDR_STICKY_RW:  rd_mux = sticky_rw_q;
      pcf_pkg::ADDR_STICKY_W1C: rd_mux = {24'h000000, sticky_w1c_q};
      pcf_pkg::ADDR_STICKY_RO:  rd_mux = {24'h000000, sticky_ro_q};
      pcf_pkg::ADDR_FUNC_EN: begin
        rd_mux[6:0]                   = fen_reg;
        rd_mux[pcf_pkg::FE_LAN_SEL]   = sel_reg;
        rd_mux[pcf_pkg::FE_INIT_DONE] = !busy_reg;
        rd_mux[pcf_pkg::FE_DEEP_PD]   = dpd_reg;
      end
      pcf_pkg::ADDR_QUERY: begin
        if (act_reg[ctrl_q[2:0]]) begin
          rd_mux[0] = 1'b1;
          rd_mux[pcf_pkg::QF_OWNER_LSB +: 3] = owner_reg[ctrl_q[2:0]];
        end else begin
          rd_mux = pcf_pkg::QUERY_ABSENT;
        end
      end
      default: rd_mux = 32'h00000000;
    endcase
  end

  // Enable loader: defaults on power-good, loaded until done, then frozen
  always_comb begin
    fen_next  = fen_reg;
    sel_next  = sel_reg;
    busy_next = busy_reg;
    if (busy_reg && nvm_valid) begin
      case (nvm_addr)
        pcf_pkg::NVM_W_LAN0: fen_next[pcf_pkg::EN_LAN0] = nvm_data[pcf_pkg::NB_LAN_EN];
        pcf_pkg::NVM_W_LAN1: fen_next[pcf_pkg::EN_LAN1] = nvm_data[pcf_pkg::NB_LAN_EN];
        pcf_pkg::NVM_W_MGMT: begin
          sel_next = nvm_data[pcf_pkg::NB_LAN_SEL];
          if (!ALT_MGMT_WORD) begin
            fen_next[pcf_pkg::EN_IDE] = nvm_data[pcf_pkg::NB_IDE_EN];
            fen_next[pcf_pkg::EN_SER] = nvm_data[pcf_pkg::NB_SER_EN];
            fen_next[pcf_pkg::EN_KCS] = nvm_data[pcf_pkg::NB_KCS_EN];
          end
        end
        pcf_pkg::NVM_W_ALT: begin
          if (ALT_MGMT_WORD) begin
            fen_next[pcf_pkg::EN_IDE] = nvm_data[pcf_pkg::NB_IDE_EN];
            fen_next[pcf_pkg::EN_SER] = nvm_data[pcf_pkg::NB_SER_EN];
            fen_next[pcf_pkg::EN_KCS] = nvm_data[pcf_pkg::NB_KCS_EN];
          end
        end
        pcf_pkg::NVM_W_EXT: begin
          fen_next[pcf_pkg::EN_USB] = nvm_data[pcf_pkg::NB_USB_EN];
          fen_next[pcf_pkg::EN_BT]  = nvm_data[pcf_pkg::NB_BT_EN];
        end
        default: fen_next = fen_reg;
      endcase
    end
    // Straps and fuse can only take away what memory grants
    if (busy_reg && nvm_done) begin
      fen_next[pcf_pkg::EN_LAN0] = fen_next[pcf_pkg::EN_LAN0] && first_port_disable_strap_n;
      fen_next[pcf_pkg::EN_LAN1] = fen_next[pcf_pkg::EN_LAN1] && second_port_disable_strap_n;
      fen_next[pcf_pkg::EN_USB]  = fen_next[pcf_pkg::EN_USB] && !usb_fuse_disable;
      busy_next = 1'b0;
    end
    if (power_good_reset) begin
      fen_next  = pcf_pkg::FUNC_EN_RST;
      sel_next  = 1'b0;
      busy_next = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    fen_reg  <= fen_next;
    sel_reg  <= sel_next;
    busy_reg <= busy_next;
  end

  // Function map; nothing shows until loading is over
  always_comb begin
    act_next = 8'h00;
    for (int s = 0; s < 8; s++) begin
      owner_next[s] = 3'h0;
    end
    if (!busy_reg) begin
      for (int f = 0; f < pcf_pkg::NUM_FUNCS; f++) begin
        if (fen_reg[f]) begin
          act_next[slot_of(f, fen_reg, sel_reg)]   = 1'b1;
          owner_next[slot_of(f, fen_reg, sel_reg)] = f[2:0];
        end
      end
    end
    dpd_next = !busy_reg && !fen_reg[pcf_pkg::EN_LAN0] && !fen_reg[pcf_pkg::EN_LAN1]
               && !fen_reg[pcf_pkg::EN_KCS];
    // Power-good empties the map in the same edge that restarts the loader
    if (!nrst || power_good_reset) begin
      act_next = 8'h00;
      dpd_next = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    act_reg  <= act_next;
    owner_reg <= owner_next;
    dpd_reg  <= dpd_next;
  end

  // Outputs from flops, except hresp tied to OKAY
  assign hreadyout       = hready_reg;
  assign hresp           = 1'b0;
  assign hrdata          = rdata_reg;
  assign func_active     = act_reg;
  assign init_done       = !busy_reg;
  assign deep_power_down = dpd_reg;

endmodule : pcf_bank

// *** pcf_bank_assertions.sv ***
// Purpose: Port-level checks on the attribute bank
// Assumes: One clock domain; ordinary reset disables most checks
// Notes:   Bound to every pcf_bank instance
`timescale 1ns/1ps
module pcf_bank_chk (
  // Clock and resets
  input wire logic       core_clk,
  input wire logic       nrst,
  input wire logic       power_good_reset,
  // Bus
  input wire logic       hsel,
  input wire logic       hready,
  input wire logic [1:0] htrans,
  input wire logic       hwrite,
  input wire logic       hreadyout,
  input wire logic       hresp,
  // Loader and functions
  input wire logic       nvm_done,
  input wire logic [7:0] func_active,
  input wire logic       init_done
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  // Every access, including refused writes, ends OKAY
  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("error response seen");
  // Read costs exactly one wait state
  property p_rd_wait;
    hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
  // Writes to any place finish without wait
  property p_wr_fast; hsel && hready && htrans[1] && hwrite |=> hreadyout; endproperty
  a_wr_fast: assert property (p_wr_fast) else $error("write stalled");
  // Ordinary reset idles the bus and empties the map
  property p_nrst_idle;
    disable iff (1'b0) !nrst |=> hreadyout && func_active == 8'h00;
  endproperty
  a_nrst_idle: assert property (p_nrst_idle) else $error("reset state wrong");
  // Slot 6 is never populated
  property p_slot6; func_active[6] == 1'b0; endproperty
  a_slot6: assert property (p_slot6) else $error("slot 6 present");
  // A second network slot implies slot 0 is filled
  property p_slot0; func_active[1] |-> func_active[0]; endproperty
  a_slot0: assert property (p_slot0) else $error("slot 0 empty");
  // Nothing is exposed while enables are loading
  property p_loading; !init_done |-> func_active == 8'h00; endproperty
  a_loading: assert property (p_loading) else $error("map shown while loading");
  // Power-good restarts the loader
  property p_pg_busy; power_good_reset |=> !init_done; endproperty
  a_pg_busy: assert property (p_pg_busy) else $error("loader not restarted");
  // Loading finishes only after the done pulse
  property p_done; $rose(init_done) |-> $past(nvm_done); endproperty
  a_done: assert property (p_done) else $error("done without pulse");
endmodule : pcf_bank_chk

bind pcf_bank pcf_bank_chk u_chk (
  .core_clk(core_clk), .nrst(nrst), .power_good_reset(power_good_reset),
  .hsel(hsel), .hready(hready), .htrans(htrans), .hwrite(hwrite),
  .hreadyout(hreadyout), .hresp(hresp), .nvm_done(nvm_done),
  .func_active(func_active), .init_done(init_done)
);

// *** pcf_host.sv ***
// Purpose: AHB-Lite host model issuing configuration accesses
// Assumes: Single whole-word transfers; the slave hreadyout is hready
// Notes:   Waits on hready with no cycle limit; the bench watchdog cuts hangs
`timescale 1ns/1ps
module pcf_host (
  // Clock
  input  wire logic        core_clk,
  // Request side
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  // Answer side
  input  wire logic        hready,
  input  wire logic [31:0] hrdata
);
  // Idle bus until the first transfer
  initial begin
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
  end

  // One transfer; read data is taken at the edge that ends the data phase
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge core_clk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge core_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hready !== 1'b1);
    q = hrdata;
  endtask : xfer

  // Change only masked bits, write back the rest as read
  task automatic rmw(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    xfer(1'b1, a, (q & ~m) | (v & m), q);
  endtask : rmw
endmodule : pcf_host

// *** pcf_pkg.sv ***
// Purpose: Constants for the configuration attribute and function enable bank
// Assumes: 32-bit AHB-Lite register bus, one word per register
// Notes:   Offsets are byte addresses; all fields sit in bits 17 down to 0
package pcf_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL       = 8'h00;
  localparam logic [7:0] ADDR_STATUS     = 8'h04;
  localparam logic [7:0] ADDR_STICKY_RW  = 8'h08;
  localparam logic [7:0] ADDR_STICKY_W1C = 8'h0c;
  localparam logic [7:0] ADDR_STICKY_RO  = 8'h10;
  localparam logic [7:0] ADDR_FUNC_EN    = 8'h14;
  localparam logic [7:0] ADDR_QUERY      = 8'h18;

  // Attribute kinds of a register cell
  localparam int KIND_RW  = 0;
  localparam int KIND_W1C = 1;
  localparam int KIND_RO  = 2;

  // Function enable bit positions in the enable word
  localparam int NUM_FUNCS = 7;
  localparam int EN_LAN0   = 0;
  localparam int EN_LAN1   = 1;
  localparam int EN_IDE    = 2;
  localparam int EN_SER    = 3;
  localparam int EN_KCS    = 4;
  localparam int EN_USB    = 5;
  localparam int EN_BT     = 6;

  // Enable defaults: network ports on, management functions off
  localparam logic [6:0] FUNC_EN_RST = 7'h03;

  // Enable word fields
  localparam int FE_LAN_SEL   = 8;
  localparam int FE_INIT_DONE = 16;
  localparam int FE_DEEP_PD   = 17;

  // Query word fields
  localparam int QF_OWNER_LSB = 1;
  localparam logic [31:0] QUERY_ABSENT = 32'hffffffff;

  // Fixed configuration function numbers
  localparam logic [2:0] SLOT_IDE = 3'h2;
  localparam logic [2:0] SLOT_SER = 3'h3;
  localparam logic [2:0] SLOT_KCS = 3'h4;
  localparam logic [2:0] SLOT_USB = 3'h5;
  localparam logic [2:0] SLOT_BT  = 3'h7;

  // Non-volatile memory words and bits
  localparam logic [7:0] NVM_W_LAN0 = 8'h10;
  localparam logic [7:0] NVM_W_LAN1 = 8'h20;
  localparam logic [7:0] NVM_W_MGMT = 8'h21;
  localparam logic [7:0] NVM_W_ALT  = 8'h49;
  localparam logic [7:0] NVM_W_EXT  = 8'h2e;
  localparam int NB_LAN_EN  = 11;
  localparam int NB_USB_EN  = 15;
  localparam int NB_BT_EN   = 13;
  localparam int NB_LAN_SEL = 0;
  localparam int NB_IDE_EN  = 1;
  localparam int NB_SER_EN  = 2;
  localparam int NB_KCS_EN  = 3;

  // Data phase of the bus slave
  typedef enum logic [1:0] {BUS_IDLE, BUS_WRITE, BUS_READ} pcf_bus_t;

endpackage : pcf_pkg

// *** pci_config_attr_and_func_enable_tb.sv ***
// Purpose: Self-checking bench for the attribute bank and function enables
// Assumes: Host model drives the bus; bench drives straps, loader, events
// Notes:   Every power-good is followed by a load sequence; the first loads no words
`timescale 1ns/1ps
module pci_config_attr_and_func_enable_tb;
  // Bench-driven inputs
  logic        core_clk, nrst, power_good_reset, aux_pwr_en, pme_en;
  logic        s0_n, s1_n, usb_off, nvm_valid, nvm_done;
  logic [7:0]  nvm_addr, evt_in, sticky_evt_in, sticky_ro_evt_in;
  logic [15:0] nvm_data;
  // Bus and outputs
  logic        hsel, hwrite, hreadyout, hresp, init_done, deep_power_down;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  func_active;
  int          n_fail = 0;
  int          n_compared = 0;
  localparam logic [63:0] ALL_ON = 64'ha000_000e_0800_0800;

  pcf_bank dut (.core_clk(core_clk), .nrst(nrst), .power_good_reset(power_good_reset),
    .aux_pwr_en(aux_pwr_en), .pme_en(pme_en), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .first_port_disable_strap_n(s0_n), .second_port_disable_strap_n(s1_n),
    .usb_fuse_disable(usb_off), .nvm_valid(nvm_valid), .nvm_addr(nvm_addr),
    .nvm_data(nvm_data), .nvm_done(nvm_done), .evt_in(evt_in),
    .sticky_evt_in(sticky_evt_in), .sticky_ro_evt_in(sticky_ro_evt_in),
    .func_active(func_active), .init_done(init_done), .deep_power_down(deep_power_down));

  pcf_host host (.core_clk(core_clk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));

  // 100 ns clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // Count and report one comparison
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic chk(input logic [7:0] a, input logic [31:0] exp);
    host.xfer(1'b0, a, 32'h0, q);
    cmp(q, exp);
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q);
  endtask : wr

  // Power-good, then n memory words (10h, 20h, 21h, 2Eh), then done
  task automatic boot(input logic [63:0] w, input int n);
    @(posedge core_clk);
    power_good_reset <= 1'b1;
    @(posedge core_clk);
    power_good_reset <= 1'b0;
    for (int i = 0; i < n; i++) begin
      nvm_valid <= 1'b1;
      nvm_addr  <= 8'(32'h2e21_2010 >> (8 * i));
      nvm_data  <= w[16*i+:16];
      @(posedge core_clk);
    end
    nvm_valid <= 1'b0;
    nvm_done  <= 1'b1;
    @(posedge core_clk);
    nvm_done <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask : boot

  // Select slot s and expect owner o, or absent
  task automatic qry(input logic [2:0] s, input logic p, input logic [2:0] o);
    host.rmw(pcf_pkg::ADDR_CTRL, 32'h7, {29'h0, s});
    chk(pcf_pkg::ADDR_QUERY, p ? {28'h0, o, 1'b1} : pcf_pkg::QUERY_ABSENT);
  endtask : qry

  task automatic end_sim;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  // Watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    end_sim();
  end

  // Main sequence
  initial begin
    {nrst, aux_pwr_en, pme_en, usb_off, nvm_valid, nvm_done} = 6'h0;
    {power_good_reset, s0_n, s1_n} = 3'h7;
    {nvm_addr, nvm_data, evt_in, sticky_evt_in, sticky_ro_evt_in} = 48'h0;
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    power_good_reset <= 1'b0;
    boot(64'h0, 0);
    chk(pcf_pkg::ADDR_FUNC_EN, 32'h0001_0003);
    cmp({24'h0, func_active}, 32'h03);
    $display("test defaults done");
    boot(ALL_ON, 4);
    chk(pcf_pkg::ADDR_FUNC_EN, 32'h0001_007f);
    cmp({24'h0, func_active}, 32'hbf);
    for (int s = 0; s < 8; s++) qry(s[2:0], s != 6, 3'(24'hc2c688 >> (3 * s)));
    boot(64'ha000_000f_0800_0800, 4);
    qry(3'h0, 1'b1, 3'h1);
    qry(3'h1, 1'b1, 3'h0);
    s0_n <= 1'b0;
    boot(64'ha000_000f_0800_0800, 4);
    cmp({24'h0, func_active}, 32'hbd);
    chk(pcf_pkg::ADDR_FUNC_EN, 32'h0001_017e);
    qry(3'h0, 1'b1, 3'h1);
    s1_n <= 1'b0;
    usb_off <= 1'b1;
    boot(64'ha000_000f_0800_0800, 4);
    cmp({24'h0, func_active}, 32'h8d);
    qry(3'h0, 1'b1, 3'h4);
    boot(64'h0000_0000_0800_0800, 4);
    cmp({31'h0, deep_power_down}, 32'h1);
    cmp({24'h0, func_active}, 32'h00);
    {s0_n, s1_n, usb_off} <= 3'h6;
    boot(ALL_ON, 4);
    $display("test enables done");
    wr(pcf_pkg::ADDR_CTRL, 32'ha5a5_5a5a);
    chk(pcf_pkg::ADDR_CTRL, 32'ha5a5_5a5a);
    wr(pcf_pkg::ADDR_CTRL, 32'h0);
    chk(pcf_pkg::ADDR_CTRL, 32'h0);
    {evt_in, sticky_evt_in, sticky_ro_evt_in} <= 24'h81_24_42;
    @(posedge core_clk);
    {evt_in, sticky_evt_in, sticky_ro_evt_in} <= 24'h0;
    chk(pcf_pkg::ADDR_STATUS, 32'h81);
    wr(pcf_pkg::ADDR_STATUS, 32'h0);
    chk(pcf_pkg::ADDR_STATUS, 32'h81);
    wr(pcf_pkg::ADDR_STATUS, 32'h01);
    chk(pcf_pkg::ADDR_STATUS, 32'h80);
    wr(pcf_pkg::ADDR_STICKY_W1C, 32'h20);
    chk(pcf_pkg::ADDR_STICKY_W1C, 32'h04);
    wr(pcf_pkg::ADDR_STICKY_RW, 32'h1234_abcd);
    wr(pcf_pkg::ADDR_STICKY_RO, 32'hff);
    chk(pcf_pkg::ADDR_STICKY_RO, 32'h42);
    wr(pcf_pkg::ADDR_FUNC_EN, 32'h0);
    chk(pcf_pkg::ADDR_FUNC_EN, 32'h0001_007f);
    wr(pcf_pkg::ADDR_QUERY, 32'h0);
    chk(pcf_pkg::ADDR_QUERY, 32'h1);
    wr(8'h40, 32'hffff_ffff);
    chk(8'h40, 32'h0);
    $display("test attributes done");
    nrst <= 1'b0;
    @(posedge core_clk);
    nrst <= 1'b1;
    chk(pcf_pkg::ADDR_STATUS, 32'h0);
    chk(pcf_pkg::ADDR_STICKY_RW, 32'h1234_abcd);
    chk(pcf_pkg::ADDR_STICKY_W1C, 32'h04);
    chk(pcf_pkg::ADDR_STICKY_RO, 32'h42);
    for (int k = 1; k < 3; k++) begin
      {pme_en, aux_pwr_en} <= k[1:0];
      boot(ALL_ON, 4);
      chk(pcf_pkg::ADDR_STICKY_RW, 32'h1234_abcd);
      chk(pcf_pkg::ADDR_STICKY_RO, 32'h42);
    end
    {pme_en, aux_pwr_en} <= 2'h0;
    boot(ALL_ON, 4);
    chk(pcf_pkg::ADDR_STICKY_RW, 32'h0);
    chk(pcf_pkg::ADDR_STICKY_W1C, 32'h0);
    chk(pcf_pkg::ADDR_STICKY_RO, 32'h0);
    $display("test sticky done");
    end_sim();
  end
endmodule : pci_config_attr_and_func_enable_tb
